// *** include/lfs_pkg.sv ***
// Constants shared by the low-frequency sweep sequencer
package lfs_pkg;
	// Frequencies are held in units of 0.1 Hz
	localparam int          FW        = 24;
	localparam int          PW        = 20;
	localparam int          KW        = 14;
	localparam logic [23:0] F_MIN     = 24'h000001;
	localparam logic [23:0] F_MAX     = 24'h989680;
	localparam logic [23:0] TONE_RST  = 24'h002710;
	localparam logic [23:0] START_RST = 24'h002710;
	localparam logic [23:0] STOP_RST  = 24'h07a120;
	localparam logic [23:0] STEP_RST  = 24'h001355;
	localparam logic [19:0] PTS_RST   = 20'h00064;
	localparam logic [19:0] PTS_MIN   = 20'h00002;
	localparam logic [19:0] PTS_MAX   = 20'hfffff;
	// Log factor in units of 0.01 percent
	localparam logic [13:0] FAC_RST   = 14'h0064;
	localparam logic [13:0] FAC_MIN   = 14'h0001;
	localparam logic [13:0] FAC_MAX   = 14'h2710;
	localparam logic [37:0] FAC_DEN   = 38'h0000002710;
	// Dwell in ticks of 100 us
	localparam logic [19:0] DWELL_MIN = 20'h00064;
	localparam logic [19:0] DWELL_MAX = 20'hf4240;
	localparam logic [19:0] DWELL_RST = 20'h00064;
	localparam int          TICK_US   = 100;
	localparam int          CLK_NS    = 10;
	localparam int          TICK_CYC  = TICK_US * 1000 / CLK_NS;
	// Operating mode codes
	localparam logic [1:0]  MODE_TONE = 2'h0;
	localparam logic [1:0]  MODE_FIX  = 2'h1;
	localparam logic [1:0]  MODE_SWP  = 2'h2;
	// Cycle mode codes
	localparam logic [1:0]  CYC_AUTO  = 2'h0;
	localparam logic [1:0]  CYC_MAN   = 2'h1;
	localparam logic [1:0]  CYC_STEP  = 2'h2;
	// Setting select codes
	localparam logic [3:0]  SEL_TONE  = 4'h0;
	localparam logic [3:0]  SEL_START = 4'h1;
	localparam logic [3:0]  SEL_STOP  = 4'h2;
	localparam logic [3:0]  SEL_MODE  = 4'h3;
	localparam logic [3:0]  SEL_CYC   = 4'h4;
	localparam logic [3:0]  SEL_SHAPE = 4'h5;
	localparam logic [3:0]  SEL_SPACE = 4'h6;
	localparam logic [3:0]  SEL_ON    = 4'h7;
	localparam logic [3:0]  SEL_DWELL = 4'h8;
	localparam logic [3:0]  SEL_STEPL = 4'h9;
	localparam logic [3:0]  SEL_STEPG = 4'ha;
	localparam logic [3:0]  SEL_PTS   = 4'hb;
	typedef enum logic [1:0] {C_IDLE, C_DIV, C_CNT} lfs_calc_e;
	typedef enum logic {S_IDLE, S_RUN} lfs_run_e;
endpackage

// *** core/lfs_sweep_seq.sv ***
// Low-frequency source sequencer: fixed tone and stepped sweep
`timescale 1ns/1ps

module lfs_sweep_seq #(
	parameter int TICK_CYC = lfs_pkg::TICK_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [3:0]  i_wr_sel,
	input  wire logic [31:0] i_wr_data,
	input  wire logic        i_exec,
	input  wire logic        i_man_cmd,
	input  wire logic        i_trig,
	input  wire logic        i_enc_step,
	input  wire logic        i_enc_dir,
	output logic      [23:0] o_freq,
	output logic             o_low_freq_source_on,
	output logic             o_sweeping,
	output logic             o_calc_busy,
	output logic      [19:0] o_points_lin,
	output logic      [19:0] o_points_log,
	output logic      [23:0] o_step_lin,
	output logic      [13:0] o_step_log
);
	localparam int TW = $clog2(TICK_CYC);

	// ***********************************************
	// Helpers
	// ***********************************************
	function automatic logic [23:0] clampf(input logic [31:0] v);
		if (v < 32'(lfs_pkg::F_MIN))
			return lfs_pkg::F_MIN;
		else if (v > 32'(lfs_pkg::F_MAX))
			return lfs_pkg::F_MAX;
		else
			return v[23:0];
	endfunction

	// Never below one unit, so a log walk always makes progress
	function automatic logic [23:0] frac(input logic [23:0] f, input logic [13:0] k);
		logic [37:0] p;
		p = (38'(f) * 38'(k)) / lfs_pkg::FAC_DEN;
		if (p == 38'h0)
			return lfs_pkg::F_MIN;
		else
			return p[23:0];
	endfunction

	// ***********************************************
	// Setting decode and registers
	// ***********************************************
	logic [23:0] tone_q, start_q, stop_q, step_lin_q, cur_q, freq_q;
	logic [19:0] dwell_q, pts_lin_q, pts_log_q, dw_q;
	logic [13:0] fac_q;
	logic [1:0]  cyc_q;
	logic        sw_q, tri_q, log_q, on_q;

	wire w_tone  = i_wr && i_wr_sel == lfs_pkg::SEL_TONE;
	wire w_start = i_wr && i_wr_sel == lfs_pkg::SEL_START;
	wire w_stop  = i_wr && i_wr_sel == lfs_pkg::SEL_STOP;
	wire w_mode  = i_wr && i_wr_sel == lfs_pkg::SEL_MODE;
	wire w_cyc   = i_wr && i_wr_sel == lfs_pkg::SEL_CYC;
	wire w_shape = i_wr && i_wr_sel == lfs_pkg::SEL_SHAPE;
	wire w_space = i_wr && i_wr_sel == lfs_pkg::SEL_SPACE;
	wire w_on    = i_wr && i_wr_sel == lfs_pkg::SEL_ON;
	wire w_dwell = i_wr && i_wr_sel == lfs_pkg::SEL_DWELL;
	wire w_stepl = i_wr && i_wr_sel == lfs_pkg::SEL_STEPL;
	wire w_stepg = i_wr && i_wr_sel == lfs_pkg::SEL_STEPG;
	wire w_pts   = i_wr && i_wr_sel == lfs_pkg::SEL_PTS;

	wire [23:0] span  = (start_q < stop_q) ? stop_q - start_q : 24'h0;
	wire [19:0] dw_in = (i_wr_data < 32'(lfs_pkg::DWELL_MIN)) ? lfs_pkg::DWELL_MIN :
		(i_wr_data > 32'(lfs_pkg::DWELL_MAX)) ? lfs_pkg::DWELL_MAX : i_wr_data[19:0];

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tone_q  <= lfs_pkg::TONE_RST;
			start_q <= lfs_pkg::START_RST;
			stop_q  <= lfs_pkg::STOP_RST;
			sw_q    <= 1'b0;
			cyc_q   <= lfs_pkg::CYC_AUTO;
			tri_q   <= 1'b0;
			log_q   <= 1'b0;
			on_q    <= 1'b0;
			dwell_q <= lfs_pkg::DWELL_RST;
		end else begin
			if (w_tone)
				tone_q <= clampf(i_wr_data);
			if (w_start)
				start_q <= clampf(i_wr_data);
			if (w_stop)
				stop_q <= clampf(i_wr_data);
			if (w_mode)
				sw_q <= i_wr_data[1:0] == lfs_pkg::MODE_SWP;
			if (w_cyc)
				cyc_q <= i_wr_data[1:0];
			if (w_shape)
				tri_q <= i_wr_data[0];
			if (w_space)
				log_q <= i_wr_data[0];
			if (w_on)
				on_q <= i_wr_data[0];
			if (w_dwell)
				dwell_q <= dw_in;
		end
	end

	// ***********************************************
	// Step width and point count calculator
	// ***********************************************
	lfs_pkg::lfs_calc_e cs_q;
	logic [23:0] num_q, den_q, quo_q, rem_q, f_q;
	logic [4:0]  bit_q;
	logic        tgt_q, bs_q;
	logic [19:0] n_q;
	logic [13:0] lo_q, hi_q, mid_q;

	wire [24:0] rsh    = {rem_q, num_q[23]};
	wire        r_ge   = rsh >= {1'b0, den_q};
	wire [23:0] r_nx   = r_ge ? 24'(rsh - {1'b0, den_q}) : rsh[23:0];
	wire [13:0] k_c    = bs_q ? mid_q : fac_q;
	wire [24:0] f_up   = {1'b0, f_q} + {1'b0, frac(f_q, k_c)};
	wire        c_end  = f_q >= stop_q || n_q == lfs_pkg::PTS_MAX;
	wire        bs_up  = n_q > pts_log_q;
	wire [13:0] lo_n   = bs_up ? mid_q + 14'h1 : lo_q;
	wire [13:0] hi_n   = bs_up ? hi_q : mid_q;
	wire [23:0] sl_in  = (i_wr_data == 32'h0) ? lfs_pkg::F_MIN :
		(i_wr_data > 32'(span) && span != 24'h0) ? span : i_wr_data[23:0];
	wire [13:0] fg_in  = (i_wr_data < 32'(lfs_pkg::FAC_MIN)) ? lfs_pkg::FAC_MIN :
		(i_wr_data > 32'(lfs_pkg::FAC_MAX)) ? lfs_pkg::FAC_MAX : i_wr_data[13:0];
	wire [19:0] pt_in  = (i_wr_data < 32'(lfs_pkg::PTS_MIN)) ? lfs_pkg::PTS_MIN :
		(i_wr_data > 32'(lfs_pkg::PTS_MAX)) ? lfs_pkg::PTS_MAX : i_wr_data[19:0];
	wire [13:0] mid0   = 14'((lfs_pkg::FAC_MIN + lfs_pkg::FAC_MAX) >> 1);

	// A new step width, log factor or point count write restarts any calculation already under way
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cs_q       <= lfs_pkg::C_IDLE;
			pts_lin_q  <= lfs_pkg::PTS_RST;
			pts_log_q  <= lfs_pkg::PTS_RST;
			step_lin_q <= lfs_pkg::STEP_RST;
			fac_q      <= lfs_pkg::FAC_RST;
			tgt_q      <= 1'b0;
			bs_q       <= 1'b0;
		end else if (w_stepl) begin
			step_lin_q <= sl_in;
			{num_q, den_q, rem_q, bit_q, tgt_q} <= {span, sl_in, 24'h0, 5'd24, 1'b0};
			cs_q <= (span == 24'h0) ? lfs_pkg::C_IDLE : lfs_pkg::C_DIV;
		end else if (w_stepg) begin
			fac_q <= fg_in;
			{f_q, n_q, bs_q} <= {start_q, 20'h1, 1'b0};
			cs_q <= lfs_pkg::C_CNT;
		end else if (w_pts && log_q) begin
			pts_log_q <= pt_in;
			{f_q, n_q, bs_q} <= {start_q, 20'h1, 1'b1};
			{lo_q, hi_q, mid_q} <= {lfs_pkg::FAC_MIN, lfs_pkg::FAC_MAX, mid0};
			cs_q <= lfs_pkg::C_CNT;
		end else if (w_pts) begin
			pts_lin_q <= pt_in;
			{num_q, den_q, rem_q, bit_q, tgt_q} <= {span, 24'(pt_in - 20'h1), 24'h0, 5'd24, 1'b1};
			cs_q <= (span == 24'h0) ? lfs_pkg::C_IDLE : lfs_pkg::C_DIV;
		end else begin
			case (cs_q)
				lfs_pkg::C_DIV: begin
					rem_q <= r_nx;
					num_q <= {num_q[22:0], 1'b0};
					quo_q <= {quo_q[22:0], r_ge};
					bit_q <= bit_q - 5'd1;
					if (bit_q == 5'd0) begin
						cs_q <= lfs_pkg::C_IDLE;
						if (tgt_q)
							step_lin_q <= clampf(32'(quo_q));
						else
							pts_lin_q <= 20'(quo_q) + 20'h1;
					end
				end
				lfs_pkg::C_CNT: begin
					if (!c_end) begin
						f_q <= f_up[23:0];
						n_q <= n_q + 20'h1;
					end else if (!bs_q) begin
						pts_log_q <= n_q;
						cs_q <= lfs_pkg::C_IDLE;
					end else if (lo_n >= hi_n) begin
						fac_q <= lo_n;
						cs_q <= lfs_pkg::C_IDLE;
					end else begin
						{lo_q, hi_q} <= {lo_n, hi_n};
						mid_q <= 14'((15'(lo_n) + 15'(hi_n)) >> 1);
						{f_q, n_q} <= {start_q, 20'h1};
					end
				end
				default: cs_q <= lfs_pkg::C_IDLE;
			endcase
		end
	end

	// ***********************************************
	// Pin synchronisers and event detection
	// ***********************************************
	logic [2:0] trg_q, enc_q;
	logic [1:0] dir_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			trg_q <= 3'h0;
			enc_q <= 3'h0;
			dir_q <= 2'h0;
		end else begin
			trg_q <= {trg_q[1:0], i_trig};
			enc_q <= {enc_q[1:0], i_enc_step};
			dir_q <= {dir_q[0], i_enc_dir};
		end
	end

	wire man    = cyc_q == lfs_pkg::CYC_MAN;
	wire trg_ev = trg_q[1] && !trg_q[2] && !man;
	wire enc_ev = enc_q[1] && !enc_q[2] && man;
	wire go     = sw_q && (trg_ev || i_exec);

	// ***********************************************
	// Sweep engine
	// ***********************************************
	lfs_pkg::lfs_run_e st_q;
	logic        up_q;
	logic [TW-1:0] tk_q;

	wire [23:0] inc    = log_q ? frac(cur_q, fac_q) : step_lin_q;
	wire [24:0] up_s   = {1'b0, cur_q} + {1'b0, inc};
	wire [23:0] up_w   = (up_s > {1'b0, stop_q}) ? stop_q : up_s[23:0];
	wire [23:0] dn_w   = (cur_q > start_q && cur_q - start_q > inc) ? cur_q - inc : start_q;
	wire        at_top = cur_q >= stop_q;
	wire        at_bot = cur_q <= start_q;
	wire        tick   = tk_q == TW'(TICK_CYC - 1);
	wire        adv    = st_q == lfs_pkg::S_RUN && tick && dw_q <= 20'h1 &&
		cyc_q == lfs_pkg::CYC_AUTO;
	wire        go_a   = go && cyc_q == lfs_pkg::CYC_AUTO;
	wire        go_s   = go && cyc_q == lfs_pkg::CYC_STEP;
	wire        ld     = go_a || adv;

	// Restarting the tick divider keeps each dwell a whole number of ticks
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || ld || tick)
			tk_q <= '0;
		else
			tk_q <= tk_q + TW'(1);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_q  <= lfs_pkg::S_IDLE;
			cur_q <= lfs_pkg::START_RST;
			up_q  <= 1'b1;
			dw_q  <= lfs_pkg::DWELL_RST;
		end else if (w_mode) begin
			st_q  <= lfs_pkg::S_IDLE;
			cur_q <= start_q;
			up_q  <= 1'b1;
		end else if (go_a) begin
			st_q  <= lfs_pkg::S_RUN;
			cur_q <= start_q;
			up_q  <= 1'b1;
			dw_q  <= dwell_q;
		end else if (go_s) begin
			cur_q <= at_top ? start_q : up_w;
		end else if (sw_q && man && i_man_cmd) begin
			cur_q <= at_top ? cur_q : up_w;
		end else if (sw_q && enc_ev) begin
			if (dir_q[1])
				cur_q <= at_top ? cur_q : up_w;
			else
				cur_q <= at_bot ? cur_q : dn_w;
		end else if (adv) begin
			dw_q <= dwell_q;
			if (up_q && !at_top)
				cur_q <= up_w;
			else if (up_q && tri_q) begin
				up_q  <= 1'b0;
				cur_q <= dn_w;
			end else if (!up_q && !at_bot)
				cur_q <= dn_w;
			else
				st_q <= lfs_pkg::S_IDLE;
		end else if (st_q == lfs_pkg::S_RUN && cyc_q != lfs_pkg::CYC_AUTO) begin
			st_q <= lfs_pkg::S_IDLE;
		end else if (st_q == lfs_pkg::S_RUN && tick) begin
			dw_q <= dw_q - 20'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			freq_q <= lfs_pkg::TONE_RST;
		else
			freq_q <= sw_q ? cur_q : tone_q;
	end

	assign o_freq               = freq_q;
	assign o_low_freq_source_on = on_q;
	assign o_sweeping           = st_q == lfs_pkg::S_RUN;
	assign o_calc_busy          = cs_q != lfs_pkg::C_IDLE;
	assign o_points_lin         = pts_lin_q;
	assign o_points_log         = pts_log_q;
	assign o_step_lin           = step_lin_q;
	assign o_step_log           = fac_q;

	// ***********************************************
	// Assertions
	// ***********************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence tri_last_s;
		st_q == lfs_pkg::S_RUN && tri_q && !go && !w_mode ##1 st_q == lfs_pkg::S_IDLE;
	endsequence

	fixed_out_a: assert property (!sw_q |=> o_freq == $past(tone_q))
		else $error("fixed tone not on output");
	sweep_out_a: assert property (sw_q |=> o_freq == $past(cur_q))
		else $error("sweep frequency not on output");
	man_hold_a: assert property (man && !i_man_cmd && !enc_ev && !w_mode |=> $stable(cur_q))
		else $error("manual mode moved without a command");
	step_trig_a: assert property (go_s && !log_q && up_s <= {1'b0, stop_q} && !w_mode
		|=> cur_q == $past(cur_q) + $past(step_lin_q))
		else $error("single step did not add step width");
	dwell_load_a: assert property (adv && !w_mode && !go_a |=> dw_q == $past(dwell_q))
		else $error("dwell not reloaded on step");
	auto_start_a: assert property (go_a && !w_mode
		|=> st_q == lfs_pkg::S_RUN && cur_q == $past(start_q))
		else $error("sweep did not start at start");
	ramp_up_a: assert property (st_q == lfs_pkg::S_RUN && !tri_q && !w_shape |=> up_q)
		else $error("ramp sweep went downward");
	tri_end_a: assert property (tri_last_s |-> !$past(up_q))
		else $error("up-down sweep ended before return");
	enc_down_a: assert property (sw_q && enc_ev && !dir_q[1] && !at_bot && !i_man_cmd
		&& !w_mode && !go |=> cur_q < $past(cur_q))
		else $error("encoder step did not lower frequency");
	cmd_up_a: assert property (sw_q && man && i_man_cmd && !at_top && !w_mode
		|=> cur_q > $past(cur_q))
		else $error("manual command did not raise frequency");
	pts_sep_a: assert property (w_pts && !log_q && !o_calc_busy |=> $stable(pts_log_q))
		else $error("linear point write changed log count");
endmodule

// *** verification/lfs_host_model.sv ***
// Remote host model: setting writes, commands, trigger and encoder pins
`timescale 1ns/1ps
module lfs_host_model (
	input  wire logic        i_ref_clk,
	output logic             o_wr,
	output logic      [3:0]  o_wr_sel,
	output logic      [31:0] o_wr_data,
	output logic             o_exec,
	output logic             o_man_cmd,
	output logic             o_trig,
	output logic             o_enc_step,
	output logic             o_enc_dir
);
	initial begin
		{o_wr, o_wr_sel, o_wr_data, o_exec, o_man_cmd} = '0;
		{o_trig, o_enc_step, o_enc_dir} = '0;
	end

	// One write strobe; data is scrambled once no longer qualified
	task automatic put(input logic [3:0] sel, input logic [31:0] data);
		@(negedge i_ref_clk);
		o_wr      <= 1'b1;
		o_wr_sel  <= sel;
		o_wr_data <= data;
		@(negedge i_ref_clk);
		o_wr      <= 1'b0;
		o_wr_data <= ~data;
	endtask

	// Execute or manual command; the manual one carries no value
	task automatic go(input bit man);
		@(negedge i_ref_clk);
		o_man_cmd <= man;
		o_exec    <= !man;
		@(negedge i_ref_clk);
		o_man_cmd <= 1'b0;
		o_exec    <= 1'b0;
	endtask

	// Asynchronous pins are held long enough for the synchronisers
	task automatic pin(input bit enc, input bit up);
		@(negedge i_ref_clk);
		o_enc_dir  <= up;
		@(negedge i_ref_clk);
		o_trig     <= !enc;
		o_enc_step <= enc;
		repeat (4) @(negedge i_ref_clk);
		o_trig     <= 1'b0;
		o_enc_step <= 1'b0;
		repeat (4) @(negedge i_ref_clk);
	endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the sweep sequencer
`timescale 1ns/1ps
module testbench;
	localparam int TICKS    = 4;
	logic        ref_clk;
	logic        rst;
	logic        wr, exec, man_cmd, trig, enc_step, enc_dir;
	logic [3:0]  wr_sel;
	logic [31:0] wr_data;
	logic [23:0] freq, step_lin;
	logic        src_on, sweeping, busy;
	logic [19:0] pts_lin, pts_log;
	logic [13:0] step_log;
	int          num_errors, checks_done, cycles;
	logic [23:0] seen[$];

	lfs_sweep_seq #(.TICK_CYC(TICKS)) i_dut (
		.i_ref_clk           (ref_clk),
		.i_rst               (rst),
		.i_wr                (wr),
		.i_wr_sel            (wr_sel),
		.i_wr_data           (wr_data),
		.i_exec              (exec),
		.i_man_cmd           (man_cmd),
		.i_trig              (trig),
		.i_enc_step          (enc_step),
		.i_enc_dir           (enc_dir),
		.o_freq              (freq),
		.o_low_freq_source_on(src_on),
		.o_sweeping          (sweeping),
		.o_calc_busy         (busy),
		.o_points_lin        (pts_lin),
		.o_points_log        (pts_log),
		.o_step_lin          (step_lin),
		.o_step_log          (step_log)
	);

	lfs_host_model host (
		.i_ref_clk (ref_clk),
		.o_wr      (wr),
		.o_wr_sel  (wr_sel),
		.o_wr_data (wr_data),
		.o_exec    (exec),
		.o_man_cmd (man_cmd),
		.o_trig    (trig),
		.o_enc_step(enc_step),
		.o_enc_dir (enc_dir)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_calc();
		int n;
		n = 0;
		settle(2);
		while (busy !== 1'b0 && n < 20000) begin
			n++;
			@(negedge ref_clk);
		end
		if (busy !== 1'b0)
			num_errors++;
	endtask

	// Points of a log walk from s up to e, factor k in 0.01 percent units
	function automatic int log_pts(input int s, input int e, input int k);
		int f;
		int n;
		f = s;
		n = 1;
		while (f < e) begin
			f = f + ((f * k / 10000 > 0) ? f * k / 10000 : 1);
			n++;
		end
		return n;
	endfunction

	// Auto sweep 20000..60000 by 20000; gaps between steps are timed
	task automatic run_sweep(input bit tri_shape, input int dwell);
		logic [23:0] exp[$];
		int          gap;
		for (int f = 20000; f <= 60000; f += 20000) exp.push_back(24'(f));
		if (tri_shape) for (int f = 40000; f >= 20000; f -= 20000) exp.push_back(24'(f));
		seen = {};
		host.go(1'b0);
		settle(1);
		chk_flag(sweeping, 1'b1);
		seen.push_back(freq);
		gap = 0;
		while (gap < 5000) begin
			@(negedge ref_clk);
			gap++;
			if (sweeping !== 1'b1) break;
			if (freq !== seen[$]) begin
				chk_val(24'(gap), 24'(dwell * TICKS));
				seen.push_back(freq);
				gap = 0;
			end
		end
		chk_val(24'(seen.size()), 24'(exp.size()));
		for (int i = 0; i < seen.size() && i < exp.size(); i++) chk_val(seen[i], exp[i]);
		$display("Test sweep shape %0d done", tri_shape);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst = 1'b1;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		settle(4);
		rst = 1'b0;
		settle(1);
		chk_val(freq, 24'h002710);
		chk_flag(src_on, 1'b0);
		chk_flag(sweeping, 1'b0);
		chk_val({4'h0, pts_lin}, 24'h000064);
		chk_val({4'h0, pts_log}, 24'h000064);
		chk_val(step_lin, 24'h001355);
		chk_val({10'h000, step_log}, 24'h000064);
		$display("Test reset done");
		host.put(lfs_pkg::SEL_TONE, 32'h0000c350);
		settle(3);
		chk_val(freq, 24'h00c350);
		// Too high a tone is clamped to the top of the range
		host.put(lfs_pkg::SEL_TONE, 32'h00ffffff);
		settle(3);
		chk_val(freq, 24'h989680);
		host.put(lfs_pkg::SEL_MODE, 32'h00000001);
		settle(3);
		chk_val(freq, 24'h989680);
		host.put(lfs_pkg::SEL_ON, 32'h00000001);
		settle(2);
		chk_flag(src_on, 1'b1);
		$display("Test fixed tone done");
		host.put(lfs_pkg::SEL_CYC, 32'h00000002);
		host.put(lfs_pkg::SEL_MODE, 32'h00000002);
		settle(3);
		chk_val(freq, 24'h002710);
		host.go(1'b0);
		settle(3);
		chk_val(freq, 24'h003a65);
		host.pin(1'b0, 1'b1);
		chk_val(freq, 24'h004dba);
		$display("Test single step done");
		host.put(lfs_pkg::SEL_PTS, 32'h0000000b);
		wait_calc();
		chk_val(step_lin, 24'h00bf68);
		chk_val({4'h0, pts_log}, 24'h000064);
		host.put(lfs_pkg::SEL_STEPL, 32'h00017ed0);
		wait_calc();
		chk_val({4'h0, pts_lin}, 24'h000006);
		host.put(lfs_pkg::SEL_START, 32'h00004e20);
		host.put(lfs_pkg::SEL_STOP, 32'h0000ea60);
		host.put(lfs_pkg::SEL_STEPL, 32'h00004e20);
		wait_calc();
		chk_val({4'h0, pts_lin}, 24'h000003);
		$display("Test point count done");
		host.put(lfs_pkg::SEL_CYC, 32'h00000001);
		host.put(lfs_pkg::SEL_MODE, 32'h00000002);
		settle(3);
		chk_val(freq, 24'h004e20);
		host.go(1'b1);
		settle(3);
		chk_val(freq, 24'h009c40);
		host.pin(1'b0, 1'b1);
		chk_val(freq, 24'h009c40);
		host.pin(1'b1, 1'b0);
		chk_val(freq, 24'h004e20);
		host.pin(1'b1, 1'b1);
		chk_val(freq, 24'h009c40);
		$display("Test manual step done");
		host.put(lfs_pkg::SEL_CYC, 32'h00000000);
		host.put(lfs_pkg::SEL_DWELL, 32'h00000001);
		host.put(lfs_pkg::SEL_MODE, 32'h00000002);
		run_sweep(1'b0, 100);
		host.put(lfs_pkg::SEL_DWELL, 32'h00000096);
		host.put(lfs_pkg::SEL_SHAPE, 32'h00000001);
		host.put(lfs_pkg::SEL_MODE, 32'h00000002);
		run_sweep(1'b1, 150);
		host.put(lfs_pkg::SEL_SPACE, 32'h00000001);
		host.put(lfs_pkg::SEL_START, 32'h00002710);
		host.put(lfs_pkg::SEL_STOP, 32'h00004e20);
		host.put(lfs_pkg::SEL_STEPG, 32'h000003e8);
		wait_calc();
		chk_val({4'h0, pts_log}, 24'(log_pts(10000, 20000, 1000)));
		chk_val({10'h000, step_log}, 24'h0003e8);
		host.put(lfs_pkg::SEL_CYC, 32'h00000002);
		host.put(lfs_pkg::SEL_MODE, 32'h00000002);
		settle(3);
		host.go(1'b0);
		settle(3);
		chk_val(freq, 24'h002af8);
		host.put(lfs_pkg::SEL_PTS, 32'h00000009);
		wait_calc();
		chk_val({4'h0, pts_log}, 24'h000009);
		chk_val({4'h0, pts_lin}, 24'h000003);
		chk_val(24'(log_pts(10000, 20000, int'(step_log))), 24'h000009);
		$display("Test log spacing done");
		rst = 1'b1;
		settle(4);
		rst = 1'b0;
		settle(1);
		chk_val(freq, 24'h002710);
		chk_val({10'h000, step_log}, 24'h000064);
		chk_val({4'h0, pts_log}, 24'h000064);
		chk_flag(src_on, 1'b0);
		$display("Test second reset done");
		test_done();
	end
endmodule
